// ===== inc/mesf_pkg.sv
// Shared constants and types of the monitor error status flag bank
package mesf_pkg;
	// Register addresses, index 0..4 in flag storage order
	localparam int NREG = 5;
	localparam logic [7:0] ADDR_DIODE = 8'h43;
	localparam logic [7:0] ADDR_THROT = 8'h44;
	localparam logic [7:0] ADDR_INPUT = 8'h46;
	localparam logic [7:0] ADDR_FAN = 8'h47;
	localparam logic [7:0] ADDR_ZONE = 8'h48;
	localparam logic [NREG-1:0][7:0] ADDRS = {ADDR_ZONE, ADDR_FAN,
		ADDR_INPUT, ADDR_THROT, ADDR_DIODE};
	localparam int IDX_THROT = 1;
	localparam int IDX_INPUT = 2;
	localparam int IDX_FAN = 3;
	localparam int IDX_HOST = 4;
	localparam logic [7:0] RESET_VAL = 8'h00;
	// Implemented bits, reserved bits read as zero
	localparam logic [NREG-1:0][7:0] VALID = {8'h1F, 8'h0F, 8'hFF,
		8'hFF, 8'hDB};
	// Diode/voltage register field positions, and POS_REGHOT in the zone register
	localparam int POS_1B = 0;
	localparam int POS_2B = 1;
	localparam int POS_FUSE = 3;
	localparam int POS_VCORE = 4;
	localparam int POS_1A = 6;
	localparam int POS_2A = 7;
	localparam int POS_REGHOT = 4;
	// Throttle register: bit 7 is the user limit flag
	localparam int POS_LIMIT = 7;
	localparam logic [7:0] THR_SUM_MASK = 8'h80;
	// Throttle ratio in 1/256 units, 256 is full throttle
	localparam logic [8:0] THR_12P5 = 9'h020;
	localparam logic [8:0] THR_25 = 9'h040;
	localparam logic [8:0] THR_50 = 9'h080;
	localparam logic [8:0] THR_75 = 9'h0C0;
	localparam logic [8:0] THR_FULL = 9'h100;
	// Sleep masking: fixed and optional masks per state, 40 bits
	localparam logic [39:0] FIX_S1 = 40'h0000000000;
	localparam logic [39:0] OPT_S1 = 40'h000FFF0000;
	localparam logic [39:0] FIX_S3 = 40'h100000FF18;
	localparam logic [39:0] OPT_S3 = 40'h030FFF00C3;
	localparam logic [39:0] FIX_S45 = 40'h100F00FF18;
	localparam logic [39:0] OPT_S45 = 40'h0300FF00C3;
	typedef enum logic [3:0] {
		SLP_S0 = 4'b0001,
		SLP_S1 = 4'b0010,
		SLP_S3 = 4'b0100,
		SLP_S45 = 4'b1000
	} mesf_sleep_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mesf_req_t;
endpackage : mesf_pkg

// ===== verilog/mesf_bank.sv
// Sticky error status flag bank with summary and alert outputs
`timescale 1ns/1ps
// Overview of operation
// RQ1 - Separate fault flag per remote diode channel 1a, 1b, 2a, 2b.
// RQ2 - Fuse flag follows input eight only in the older regulator mode.
// RQ3 - Core-voltage flag sets when supply reading misses the requested code.
// RQ4 - Throttle-any flag sets for any nonzero throttling.
// RQ5 - Exactly one throttle bucket flag matching the measured ratio sets.
// RQ6 - Top throttle bit sets when ratio exceeds the user limit.
// RQ7 - Only the limit flag of throttle bits feeds the management summary.
// RQ8 - Each general pin flag sets when pin is low, unless masked.
// RQ9 - Fan flags set above tach limit; sleep masking per state.
// RQ10 - Host summary bit sets when any host group flag is set.
// RQ11 - Fixed throttle buckets never feed the host summary.
// RQ12 - Flags stay set until software clears them.
// RQ13 - Host flag with live condition survives a clear.
// RQ14 - Software clears a flag by writing one; zero leaves it.
// RQ15 - Sleep state suppresses listed flags, starred ones when selected.
// RQ16 - Zone flags set out of limits; zones 1, 2 optionally sleep masked.
// RQ17 - Regulator-hot flag bit four, masked in S3 and S4/5.
// RQ18 - Management summary bit sets when any management flag is set.
// RQ19 - Alert output follows management summary when alerting is enabled.
// RQ20 - Alert-standard mode adds clear on read for management flags.
// RQ21 - Masked flags clear despite live condition; unmasked ones do not.
// RQ22 - Reserved bits read zero, ignore writes; all registers reset zero.
// RQ23 - Summary bits recomputed every clock from eligible flags.
module mesf_bank #(
	parameter logic [7:0] VCORE_TOL = 8'h04
) (
	// Clock, reset, enable
	input logic i_mclk,
	input logic i_rst,
	input logic i_ce,
	// Register access from the serial interface engine
	input mesf_pkg::mesf_req_t i_req,
	output logic [7:0] o_reg_rdata_ff,
	// Configuration
	input logic i_asf_mode,
	input logic i_alert_en,
	input logic i_legacy_vid_mode,
	input mesf_pkg::mesf_sleep_t i_sleep_state,
	input logic [39:0] i_sel_s1,
	input logic [39:0] i_sel_s3,
	input logic [39:0] i_sel_s45,
	input logic [7:0] i_gpi_mask,
	// Device pins, asynchronous
	input logic [7:0] i_gpio_pin,
	input logic i_fuse_input_n,
	input logic i_regulator_overtemp_input_n,
	// Monitoring events from same-clock logic
	input logic [3:0] i_remote_fault,
	input logic i_adc_valid,
	input logic [7:0] i_core_supply_channel,
	input logic [7:0] i_cpu_voltage_request_code,
	input logic i_throttle_valid,
	input logic [8:0] i_throttle_ratio,
	input logic [8:0] i_throttle_limit,
	input logic [3:0][15:0] i_tach_count,
	input logic [3:0][15:0] i_tach_limit,
	input logic [3:0] i_zone_out,
	// Summaries
	output logic o_mgmt_summary_ff,
	output logic o_host_summary_ff,
	output logic o_alert_ff
);
	localparam int NR = mesf_pkg::NREG;
	logic [9:0] sync1_ff;
	logic [9:0] sync2_ff;
	logic [NR-1:0][7:0] flags_ff;
	logic [NR-1:0][7:0] nxt_flags;
	logic [NR-1:0][7:0] cond;
	logic [NR-1:0][7:0] ev;
	logic [NR-1:0][7:0] clr;
	logic [NR-1:0] hit;
	logic [39:0] mask_sleep;
	logic [7:0] rd_mux;
	logic [7:0] thr_vec;
	logic [5:0] bucket;
	logic [3:0] tach_over;
	logic [8:0] chan_x;
	logic [8:0] code_x;
	logic [8:0] tol_x;
	logic vcore_bad;
	logic fuse_ev;
	logic nxt_mgmt;
	logic nxt_host;
	logic in_s1;
	logic in_s3;
	logic in_s45;

	// Two-stage synchroniser for all pins
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			sync1_ff <= 10'h3FF;
			sync2_ff <= 10'h3FF;
		end
		else if (i_ce)
		begin
			sync1_ff <= {i_regulator_overtemp_input_n, i_fuse_input_n,
				i_gpio_pin};
			sync2_ff <= sync1_ff;
		end
	end

	// Core supply against the requested level, outside tolerance
	assign chan_x = {1'b0, i_core_supply_channel};
	assign code_x = {1'b0, i_cpu_voltage_request_code};
	assign tol_x = {1'b0, VCORE_TOL};
	assign vcore_bad = i_adc_valid && ((chan_x > code_x + tol_x) ||
		(chan_x + tol_x < code_x)); // RQ3
	assign fuse_ev = ~sync2_ff[8] & i_legacy_vid_mode; // RQ2

	// Throttle buckets: one-hot by ratio range
	assign bucket[0] = (i_throttle_ratio != 9'h000) &&
		(i_throttle_ratio < mesf_pkg::THR_12P5); // RQ5
	assign bucket[1] = (i_throttle_ratio >= mesf_pkg::THR_12P5) &&
		(i_throttle_ratio < mesf_pkg::THR_25);
	assign bucket[2] = (i_throttle_ratio >= mesf_pkg::THR_25) &&
		(i_throttle_ratio < mesf_pkg::THR_50);
	assign bucket[3] = (i_throttle_ratio >= mesf_pkg::THR_50) &&
		(i_throttle_ratio < mesf_pkg::THR_75);
	assign bucket[4] = (i_throttle_ratio >= mesf_pkg::THR_75) &&
		(i_throttle_ratio < mesf_pkg::THR_FULL);
	assign bucket[5] = (i_throttle_ratio >= mesf_pkg::THR_FULL);
	assign thr_vec = i_throttle_valid ? {
		(i_throttle_ratio > i_throttle_limit), // RQ6
		bucket,
		(i_throttle_ratio != 9'h000)} : 8'h00; // RQ4

	genvar f;
	generate
		for (f = 0; f < 4; f++)
		begin : g_tach
			assign tach_over[f] = i_tach_count[f] > i_tach_limit[f]; // RQ9
		end
	endgenerate

	// Raw conditions per register
	// Fault inputs: bit0 1a, bit1 1b, bit2 2a, bit3 2b
	assign cond[0] = {i_remote_fault[2], i_remote_fault[0], 1'b0,
		vcore_bad, fuse_ev, 1'b0, i_remote_fault[3],
		i_remote_fault[1]}; // RQ1
	assign cond[1] = thr_vec;
	assign cond[2] = ~sync2_ff[7:0] & ~i_gpi_mask; // RQ8
	assign cond[3] = {4'h0, tach_over};
	assign cond[4] = {3'h0, ~sync2_ff[9], i_zone_out}; // RQ16 RQ17

	// Sleep masking: fixed entries always, starred ones when selected
	assign in_s1 = (i_sleep_state == mesf_pkg::SLP_S1);
	assign in_s3 = (i_sleep_state == mesf_pkg::SLP_S3);
	assign in_s45 = (i_sleep_state == mesf_pkg::SLP_S45);
	assign mask_sleep =
		({40{in_s1}} & (mesf_pkg::FIX_S1 | (mesf_pkg::OPT_S1 & i_sel_s1))) |
		({40{in_s3}} & (mesf_pkg::FIX_S3 | (mesf_pkg::OPT_S3 & i_sel_s3))) |
		({40{in_s45}} &
		(mesf_pkg::FIX_S45 | (mesf_pkg::OPT_S45 & i_sel_s45))); // RQ15

	genvar r;
	generate
		for (r = 0; r < NR; r++)
		begin : g_reg
			assign hit[r] = (i_req.addr == mesf_pkg::ADDRS[r]);
			assign ev[r] = cond[r] & ~mask_sleep[r*8 +: 8] &
				mesf_pkg::VALID[r]; // RQ22
			// Write one clears; read clears management group in ASF mode
			assign clr[r] = ({8{i_req.wr && hit[r]}} & i_req.wdata) |
				{8{i_asf_mode && i_req.rd && hit[r] &&
				(r != mesf_pkg::IDX_HOST)}}; // RQ14 RQ20
			// Live unmasked event wins over any clear
			assign nxt_flags[r] = (flags_ff[r] & ~clr[r]) | ev[r]; // RQ12 RQ13 RQ21
		end
	endgenerate

	assign rd_mux = ({8{hit[0]}} & flags_ff[0]) |
		({8{hit[1]}} & flags_ff[1]) | ({8{hit[2]}} & flags_ff[2]) |
		({8{hit[3]}} & flags_ff[3]) | ({8{hit[4]}} & flags_ff[4]);
	assign nxt_mgmt = (|flags_ff[0]) |
		(|(flags_ff[1] & mesf_pkg::THR_SUM_MASK)) |
		(|flags_ff[2]) | (|flags_ff[3]); // RQ7 RQ18 RQ23
	assign nxt_host = |flags_ff[mesf_pkg::IDX_HOST]; // RQ10 RQ11 RQ23

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			flags_ff <= {NR{mesf_pkg::RESET_VAL}}; // RQ22
		else if (i_ce)
			flags_ff <= nxt_flags;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			o_reg_rdata_ff <= 8'h00;
			o_mgmt_summary_ff <= 1'b0;
			o_host_summary_ff <= 1'b0;
			o_alert_ff <= 1'b0;
		end
		else if (i_ce)
		begin
			if (i_req.rd)
				o_reg_rdata_ff <= rd_mux;
			o_mgmt_summary_ff <= nxt_mgmt;
			o_host_summary_ff <= nxt_host;
			o_alert_ff <= nxt_mgmt & i_alert_en; // RQ19
		end
	end

	// Checks
	flag_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ13
		$past(i_ce) && !$past(i_rst) |->
		((flags_ff & $past(ev)) == $past(ev)))
		else $error("live event did not leave its flag set");
	sticky_bits_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ12
		$past(i_ce) && !$past(i_rst) |->
		((($past(flags_ff) & ~flags_ff) & ~$past(clr)) == '0))
		else $error("flag dropped without a clear");
	mgmt_sum_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ18
		$past(i_ce) && !$past(i_rst) |-> o_mgmt_summary_ff ==
		(|{$past(flags_ff[0]), $past(flags_ff[1][7]),
		$past(flags_ff[2]), $past(flags_ff[3])}))
		else $error("management summary mismatch");
	host_sum_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ10
		$past(i_ce) && !$past(i_rst) |->
		o_host_summary_ff == (|$past(flags_ff[4])))
		else $error("host summary mismatch");
	alert_out_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ19
		o_alert_ff |-> o_mgmt_summary_ff && $past(i_alert_en))
		else $error("alert without summary or enable");
	bucket_one_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ5
		i_throttle_valid |-> $onehot0(bucket) &&
		((|bucket) == (i_throttle_ratio != 9'h000)))
		else $error("throttle bucket not unique");
	fuse_gate_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ2
		$rose(flags_ff[0][mesf_pkg::POS_FUSE]) |->
		$past(i_legacy_vid_mode))
		else $error("fuse flag set outside legacy mode");
	fan_sleep_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ9
		$past(i_sleep_state) == mesf_pkg::SLP_S45 && !$past(i_rst) |->
		((flags_ff[3] & ~$past(flags_ff[3])) == 8'h00))
		else $error("fan flag set in deep sleep");
	gpi_mask_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ8
		!$past(i_rst) |->
		((flags_ff[2] & ~$past(flags_ff[2]) & $past(i_gpi_mask)) == 8'h00))
		else $error("masked input flag set");
	// Reserved positions never hold a one
	resv_zero_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ22
		(flags_ff & ~mesf_pkg::VALID) == '0)
		else $error("reserved flag bit set");
	unmapped_rd_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ22
		$past(i_ce) && $past(i_req.rd) && !$past(i_rst) &&
		$past(hit) == '0 |-> o_reg_rdata_ff == 8'h00)
		else $error("unmapped read not zero");
	thr_sum_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ7
		$past(i_ce) && !$past(i_rst) && $past(flags_ff[0]) == 8'h00 &&
		!$past(flags_ff[1][7]) && $past(flags_ff[2]) == 8'h00 &&
		$past(flags_ff[3]) == 8'h00 |-> !o_mgmt_summary_ff)
		else $error("bucket flag raised the summary");
	diode_set_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ1
		$past(i_ce) && !$past(i_rst) &&
		$past(i_sleep_state) == mesf_pkg::SLP_S0 |->
		(({flags_ff[0][mesf_pkg::POS_2B],
		flags_ff[0][mesf_pkg::POS_2A],
		flags_ff[0][mesf_pkg::POS_1B],
		flags_ff[0][mesf_pkg::POS_1A]} &
		$past(i_remote_fault)) == $past(i_remote_fault)))
		else $error("diode fault flag missed");
	limit_set_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ6
		$past(i_ce) && !$past(i_rst) && $past(i_throttle_valid) &&
		$past(i_sleep_state) == mesf_pkg::SLP_S0 &&
		$past(i_throttle_ratio) > $past(i_throttle_limit) |->
		flags_ff[1][mesf_pkg::POS_LIMIT])
		else $error("throttle limit flag missed");
	thr_any_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ4
		$past(i_ce) && !$past(i_rst) && $past(i_throttle_valid) &&
		$past(i_sleep_state) == mesf_pkg::SLP_S0 &&
		$past(i_throttle_ratio) != 9'h000 |-> flags_ff[1][0])
		else $error("throttle event flag missed");
	fan_set_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ9
		$past(i_ce) && !$past(i_rst) &&
		$past(i_sleep_state) == mesf_pkg::SLP_S0 |->
		((flags_ff[3][3:0] & $past(tach_over)) == $past(tach_over)))
		else $error("fan flag missed");
	gpi_set_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ8
		$past(i_ce) && !$past(i_rst) &&
		$past(i_sleep_state) == mesf_pkg::SLP_S0 |->
		((flags_ff[2] | $past(sync2_ff[7:0]) | $past(i_gpi_mask)) ==
		8'hFF))
		else $error("low input pin not flagged");
	zone_live_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ16
		$past(i_ce) && !$past(i_rst) |->
		((flags_ff[4][3:2] & $past(i_zone_out[3:2])) ==
		$past(i_zone_out[3:2])))
		else $error("zone flag missed");
	reg_hot_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ17
		!$past(i_rst) && ($past(i_sleep_state) == mesf_pkg::SLP_S3 ||
		$past(i_sleep_state) == mesf_pkg::SLP_S45) |->
		!$rose(flags_ff[4][mesf_pkg::POS_REGHOT]))
		else $error("regulator flag set in sleep");
	host_rd_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ12
		$past(i_ce) && !$past(i_rst) && !$past(i_req.wr) |->
		(($past(flags_ff[4]) & ~flags_ff[4]) == 8'h00))
		else $error("host flag cleared without a write");
	rd_keep_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ20
		$past(i_ce) && !$past(i_rst) && !$past(i_asf_mode) &&
		!$past(i_req.wr) |-> (($past(flags_ff) & ~flags_ff) == '0))
		else $error("flag cleared by read outside alert mode");
	asf_clr_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ20
		$past(i_ce) && !$past(i_rst) && $past(i_asf_mode) &&
		$past(i_req.rd) && $past(hit[0]) && $past(ev[0]) == 8'h00 |->
		flags_ff[0] == 8'h00)
		else $error("read did not clear in alert mode");
endmodule : mesf_bank

// ===== sim/mesf_sw_model.sv
// Software side model issuing register accesses to the flag bank
`timescale 1ns/1ps
module mesf_sw_model (
	// Clock
	input logic i_mclk,
	// Register request towards the bank
	output mesf_pkg::mesf_req_t o_req
);
	initial o_req = '0;
	// One-cycle access, launched and dropped right after rising edges
	task automatic access(input logic wr, input logic [7:0] addr,
		input logic [7:0] data);
		@(posedge i_mclk);
		o_req <= '{wr: wr, rd: !wr, addr: addr, wdata: data};
		@(posedge i_mclk);
		o_req <= '0;
	endtask : access
endmodule : mesf_sw_model

// ===== sim/tb_monitor_error_status_flags.sv
// Self-checking bench for the error status flag bank
`timescale 1ns/1ps
module tb_monitor_error_status_flags;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic ce = 1'b1, asf = 1'b0, alert_en = 1'b1, legacy = 1'b1;
	mesf_pkg::mesf_sleep_t slp = mesf_pkg::SLP_S0;
	mesf_pkg::mesf_req_t req;
	logic [39:0] sel = '0;
	logic [7:0] gmask = 8'h08, pin = 8'hFF, supply = 8'h80, code = 8'h80;
	logic fuse_n = 1'b1, hot_n = 1'b1, adc_v = 1'b0, thr_v = 1'b0;
	logic [3:0] rfault = '0, zone = '0;
	logic [8:0] ratio = '0, limit = 9'h1FF;
	logic [3:0][15:0] tach = '0, tlim = '0;
	logic [7:0] rdata;
	logic msum, hsum, alert;
	int miscompares = 0, comparisons = 0;
	localparam logic [8:0] RTAB [6] = '{9'h001, 9'h020, 9'h040, 9'h080,
		9'h0C0, 9'h100};
	localparam logic [7:0] ETAB [6] = '{8'h03, 8'h05, 8'h09, 8'h11, 8'h21,
		8'h41};
	always #5 i_mclk = ~i_mclk;
	mesf_sw_model i_mesf_sw_model (.i_mclk(i_mclk), .o_req(req));
	mesf_bank i_mesf_bank (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(ce),
		.i_req(req), .o_reg_rdata_ff(rdata), .i_asf_mode(asf),
		.i_alert_en(alert_en), .i_legacy_vid_mode(legacy),
		.i_sleep_state(slp), .i_sel_s1(sel), .i_sel_s3(sel),
		.i_sel_s45(sel), .i_gpi_mask(gmask), .i_gpio_pin(pin),
		.i_fuse_input_n(fuse_n), .i_regulator_overtemp_input_n(hot_n),
		.i_remote_fault(rfault), .i_adc_valid(adc_v),
		.i_core_supply_channel(supply), .i_cpu_voltage_request_code(code),
		.i_throttle_valid(thr_v), .i_throttle_ratio(ratio),
		.i_throttle_limit(limit), .i_tach_count(tach), .i_tach_limit(tlim),
		.i_zone_out(zone), .o_mgmt_summary_ff(msum),
		.o_host_summary_ff(hsum), .o_alert_ff(alert));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		i_mesf_sw_model.access(1'b0, a, 8'h00);
		#1;
		chk(rdata, exp);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_mesf_sw_model.access(1'b1, a, d);
	endtask : wr
	task automatic wait_n(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : wait_n
	task automatic report_and_stop();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#50000;
		miscompares++;
		report_and_stop();
	end
	initial
	begin
		repeat (12) @(posedge i_mclk);
		i_rst <= 1'b0;
		for (int i = 0; i < mesf_pkg::NREG; i++)
			rd(mesf_pkg::ADDRS[i], 8'h00);
		rd(8'h45, 8'h00);
		@(posedge i_mclk);
		zone <= 4'h4;
		@(posedge i_mclk);
		zone <= 4'h0;
		wait_n(3);
		chk({7'h00, hsum}, 8'h01);
		rd(8'h48, 8'h04);
		wr(8'h48, 8'hFB);
		rd(8'h48, 8'h04);
		wr(8'h48, 8'h04);
		wait_n(2);
		chk({7'h00, hsum}, 8'h00);
		zone <= 4'h8;
		wait_n(3);
		wr(8'h48, 8'h08);
		rd(8'h48, 8'h08);
		zone <= 4'h0;
		slp <= mesf_pkg::SLP_S3;
		hot_n <= 1'b0;
		wait_n(6);
		rd(8'h48, 8'h08);
		slp <= mesf_pkg::SLP_S0;
		wait_n(4);
		hot_n <= 1'b1;
		wait_n(4);
		rd(8'h48, 8'h18);
		wr(8'h48, 8'h18);
		tach[1] <= 16'h0001;
		wait_n(1);
		tach[1] <= 16'h0000;
		wait_n(3);
		rd(8'h47, 8'h02);
		wr(8'h47, 8'hFF);
		rd(8'h47, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			@(posedge i_mclk);
			ratio <= RTAB[i];
			thr_v <= 1'b1;
			@(posedge i_mclk);
			thr_v <= 1'b0;
			wait_n(3);
			chk({6'h00, msum, alert}, 8'h00);
			rd(8'h44, ETAB[i]);
			wr(8'h44, 8'hFF);
		end
		limit <= 9'h080;
		ratio <= 9'h081;
		thr_v <= 1'b1;
		wait_n(1);
		thr_v <= 1'b0;
		wait_n(3);
		chk({6'h00, msum, alert}, 8'h03);
		rd(8'h44, 8'h91);
		rd(8'h44, 8'h91);
		wr(8'h44, 8'hFF);
		wait_n(3);
		chk({6'h00, msum, alert}, 8'h00);
		asf <= 1'b1;
		rfault <= 4'hF;
		fuse_n <= 1'b0;
		adc_v <= 1'b1;
		supply <= 8'h90;
		wait_n(2);
		rfault <= 4'h0;
		fuse_n <= 1'b1;
		adc_v <= 1'b0;
		wait_n(4);
		rd(8'h43, 8'hDB);
		rd(8'h43, 8'h00);
		legacy <= 1'b0;
		fuse_n <= 1'b0;
		wait_n(4);
		fuse_n <= 1'b1;
		wait_n(4);
		rd(8'h43, 8'h00);
		pin <= 8'hF3;
		wait_n(5);
		pin <= 8'hFF;
		wait_n(4);
		chk({7'h00, msum}, 8'h01);
		rd(8'h46, 8'h04);
		pin <= 8'hFA;
		wait_n(4);
		gmask <= 8'h0C;
		wr(8'h46, 8'h05);
		rd(8'h46, 8'h01);
		alert_en <= 1'b0;
		wait_n(2);
		chk({6'h00, msum, alert}, 8'h02);
		pin <= 8'hFF;
		sel <= 40'h0100000000;
		slp <= mesf_pkg::SLP_S45;
		tach[0] <= 16'h0001;
		zone <= 4'h1;
		rfault <= 4'h2;
		wait_n(4);
		rd(8'h47, 8'h00);
		rd(8'h48, 8'h00);
		rd(8'h43, 8'h01);
		slp <= mesf_pkg::SLP_S0;
		wait_n(2);
		rd(8'h47, 8'h01);
		rd(8'h48, 8'h01);
		report_and_stop();
	end
endmodule : tb_monitor_error_status_flags
